// >>> logic/power_path_pkg.sv
`default_nettype none
package power_path_pkg;
   // Register byte offsets
   localparam logic [7:0]  REG_CTRL_OFS     = 8'h00;
   localparam logic [7:0]  REG_VLIM_OFS     = 8'h04;
   localparam logic [7:0]  REG_ILIM_OFS     = 8'h08;
   localparam logic [7:0]  REG_STATUS_OFS   = 8'h0C;
   localparam logic [7:0]  REG_VLIM_EFF_OFS = 8'h10;
   localparam logic [7:0]  REG_ILIM_EFF_OFS = 8'h14;
   // Control register fields
   localparam int unsigned CTRL_HIZ_BIT  = 0;
   localparam int unsigned CTRL_LLD_BIT  = 1;
   localparam int unsigned CTRL_CHG_BIT  = 2;
   localparam int unsigned CTRL_BST_BIT  = 3;
   localparam int unsigned CTRL_BSD_BIT  = 4;
   localparam int unsigned CTRL_TRK_LSB  = 5;
   localparam int unsigned CTRL_BSTV_LSB = 7;
   localparam logic [31:0] CTRL_MASK     = 32'h0000_01FF;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0104;
   // Status register fields
   localparam int unsigned ST_VBUS_LSB   = 0;
   localparam int unsigned ST_MINSYS_BIT = 3;
   localparam int unsigned ST_VLIM_BIT   = 4;
   localparam int unsigned ST_ILIM_BIT   = 5;
   localparam int unsigned ST_SUPP_BIT   = 6;
   localparam int unsigned ST_CLAMP_BIT  = 7;
   localparam int unsigned ST_MODE_LSB   = 8;
   localparam int unsigned ST_BATSW_BIT  = 11;
   // Values in mV and mA, then the input status codes
   localparam logic [15:0] VLIM_RESET_MV  = 16'h1194;
   localparam logic [15:0] VLIM_MIN_MV    = 16'h0F3C;
   localparam logic [15:0] VLIM_MAX_MV    = 16'h1518;
   localparam logic [15:0] ILIM_RESET_MA  = 16'h01F4;
   localparam logic [15:0] SOFT_ILIM_MA   = 16'h00C8;
   localparam logic [15:0] SYS_MIN_OFS_MV = 16'h00B4;
   localparam logic [15:0] SYS_BAT_OFS_MV = 16'h0032;
   localparam logic [15:0] SUPP_VDS_MV    = 16'h001E;
   localparam logic [15:0] BOOST_IMAX_MA  = 16'h03E8;
   localparam logic [15:0] BOOST_4600_MV  = 16'h11F8;
   localparam logic [15:0] BOOST_4750_MV  = 16'h128E;
   localparam logic [15:0] BOOST_5000_MV  = 16'h1388;
   localparam logic [15:0] BOOST_5150_MV  = 16'h141E;
   localparam logic [15:0] TRK_OFS1_MV    = 16'h00C8;
   localparam logic [15:0] TRK_OFS2_MV    = 16'h00FA;
   localparam logic [15:0] TRK_OFS3_MV    = 16'h012C;
   localparam logic [2:0]  VBUS_NONE      = 3'h0;
   localparam logic [2:0]  VBUS_BOOST     = 3'h7;

   typedef enum logic [2:0] {
      MODE_IDLE,
      MODE_HIZ,
      MODE_BUCK_START,
      MODE_BUCK,
      MODE_BOOST
   } mode_e;

   // Comparator results and measured values from the analog side
   typedef struct packed {
      logic        adapter_present;
      logic        sys_below_short;
      logic        sys_above_short_release;
      logic        sys_below_min;
      logic        sys_below_bat;
      logic        bat_above_boost_min;
      logic        vbus_below_bat_sleep;
      logic        ts_in_boost_window;
      logic        bat_depleted;
      logic        input_current_over;
      logic        input_voltage_under;
      logic        charge_current_zero;
      logic        new_charge_ok;
      logic        charge_terminated;
      logic        current_limit_established;
      logic [2:0]  source_type;
      logic [15:0] bat_mv;
   } sense_s;

   // Controls toward the power stage
   typedef struct packed {
      logic        buck_switches_en;
      logic        input_blocking_switch_on;
      logic        internal_regulator_on;
      logic        bias_on;
      logic        battery_switch_on;
      logic        battery_switch_linear;
      logic        boost_en;
      logic        light_load_en;
      logic        charge_reduce;
      logic        supplement;
      logic        sys_ref_battery;
      logic [15:0] input_voltage_limit_mv;
      logic [15:0] input_current_limit_ma;
      logic [15:0] boost_target_mv;
      logic [15:0] boost_current_max_ma;
      logic [15:0] sys_offset_mv;
      logic [15:0] vds_min_mv;
   } power_ctrl_s;
endpackage : power_path_pkg
`default_nettype wire

// >>> logic/power_path_mode_control.sv
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) Fixed input voltage limit, default 4.5 V, programmable 3.9 V to 5.4 V.
// (RULE2) Tracking on: limit is larger of programmed and battery plus offset.
// (RULE3) Buck switches start once current limit set; battery switch follows charge enable.
// (RULE4) Rail below short threshold clamps current limit to min of 200 mA.
// (RULE5) Light-load pulse mode on by default in buck and boost; disable bit stops it.
// (RULE6) High-impedance bit with adapter turns off blocking switch, regulator, bias.
// (RULE7) Boost target two-bit select, default 5 V, current up to 1 A.
// (RULE8) Host picks boost target at least 350 mV above battery.
// (RULE9) Boost only with switch-disable 0, charge 0, boost 1 and analog conditions; the code also boosts with charge 1 when boost is 1.
// (RULE10) Input status field reads 111 during boost.
// (RULE11) Input blocking switch stays off throughout boost.
// (RULE12) Both enables set: adapter arrival with charge conditions selects charging.
// (RULE13) Both enables set: adapter removal with boost conditions enters boost.
// (RULE14) Below minimum system, linear switch at +180 mV; else +50 mV over battery.
// (RULE15) Minimum-system status bit set while in minimum system regulation.
// (RULE16) Input overload reduces charge current until both limits hold.
// (RULE17) Voltage- or current-limit status bit set per active limit.
// (RULE18) System below battery at zero charge enters supplement, 30 mV least drop.
// (RULE19) Battery below depletion turns switch off and leaves supplement.
// (RULE20) High-impedance bit turns internal regulator off; battery feeds system.
// (RULE21) Inputs sampled and mode plus status recomputed every clock.
module power_path_mode_control
   import power_path_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [ADDR_W-1:0]          address_i,
   input  wire logic                       read_i,
   input  wire logic                       write_i,
   input  wire logic [31:0]                writedata_i,
   input  wire logic [3:0]                 byteenable_i,
   output logic      [31:0]                readdata_o,
   output logic                            waitrequest_o,
   input  wire power_path_pkg::sense_s      sense_i,
   output power_path_pkg::power_ctrl_s      power_o,
   output logic      [2:0]                 mode_o
);
   import power_path_pkg::*;

   // Offsets are declared eight bits wide, so any bus narrower than eight bits is rejected
   if (ADDR_W < 8) begin : g_addr_check
      $error("ADDR_W must be at least 8");
   end

   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      max16 = (a > b) ? a : b;
   endfunction : max16

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      min16 = (a < b) ? a : b;
   endfunction : min16

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      be_merge = r;
   endfunction : be_merge

   logic [31:0] ctrl_q;
   logic [15:0] vlim_q;
   logic [15:0] ilim_q;
   logic [31:0] status_q;
   logic [31:0] status_d;
   logic        clamp_q;
   logic        supp_q;
   logic        supp_d;
   logic        waitreq_q;
   logic [31:0] rdata_q;
   mode_e       mode_q;
   mode_e       mode_d;
   power_ctrl_s pwr_q;
   power_ctrl_s pwr_d;

   // Control bit decode
   wire       hiz_en   = ctrl_q[CTRL_HIZ_BIT];
   wire       lld      = ctrl_q[CTRL_LLD_BIT];
   wire       chg_en   = ctrl_q[CTRL_CHG_BIT];
   wire       bst_en   = ctrl_q[CTRL_BST_BIT];
   wire       bsd      = ctrl_q[CTRL_BSD_BIT];
   wire [1:0] trk_sel  = ctrl_q[CTRL_TRK_LSB +: 2];
   wire [1:0] bstv_sel = ctrl_q[CTRL_BSTV_LSB +: 2];

   // Bus decode; a transfer is accepted on the cycle waitrequest is low
   wire        req      = read_i | write_i;
   wire        accept   = req & ~waitreq_q;
   wire        sel_ctrl = address_i == ADDR_W'(REG_CTRL_OFS);
   wire        sel_vlim = address_i == ADDR_W'(REG_VLIM_OFS);
   wire        sel_ilim = address_i == ADDR_W'(REG_ILIM_OFS);
   wire        sel_stat = address_i == ADDR_W'(REG_STATUS_OFS);
   wire        sel_veff = address_i == ADDR_W'(REG_VLIM_EFF_OFS);
   wire        sel_ieff = address_i == ADDR_W'(REG_ILIM_EFF_OFS);
   wire        wr_acc   = write_i & accept;
   wire [31:0] ctrl_new = be_merge(ctrl_q, writedata_i, byteenable_i) & CTRL_MASK;
   wire [31:0] vlim_raw = be_merge({16'h0000, vlim_q}, writedata_i, byteenable_i);
   wire [31:0] ilim_raw = be_merge({16'h0000, ilim_q}, writedata_i, byteenable_i);
   // Out-of-range voltage limits are pinned to the nearest legal value
   wire [15:0] vlim_new = (vlim_raw[15:0] < VLIM_MIN_MV) ? VLIM_MIN_MV :
                          (vlim_raw[15:0] > VLIM_MAX_MV) ? VLIM_MAX_MV : vlim_raw[15:0];
   wire [31:0] rd_mux   = sel_ctrl ? ctrl_q :
                          sel_vlim ? {16'h0000, vlim_q} :
                          sel_ilim ? {16'h0000, ilim_q} :
                          sel_stat ? status_q :
                          sel_veff ? {16'h0000, pwr_q.input_voltage_limit_mv} :
                          sel_ieff ? {16'h0000, pwr_q.input_current_limit_ma} : 32'h0000_0000;

   // Effective limits
   wire [15:0] trk_ofs = (trk_sel == 2'h1) ? TRK_OFS1_MV :
                         (trk_sel == 2'h2) ? TRK_OFS2_MV : TRK_OFS3_MV;
   wire [16:0] trk_sum = {1'b0, sense_i.bat_mv} + {1'b0, trk_ofs};
   wire [15:0] trk_mv  = trk_sum[16] ? 16'hFFFF : trk_sum[15:0];
   // (RULE1) fixed limit
   // (RULE2) battery tracking
   wire [15:0] vlim_eff = (trk_sel == 2'h0) ? vlim_q : max16(vlim_q, trk_mv);
   // (RULE4) soft-start clamp
   wire [15:0] ilim_eff = clamp_q ? min16(SOFT_ILIM_MA, ilim_q) : ilim_q;
   // (RULE7) boost target
   wire [15:0] bst_mv   = (bstv_sel == 2'h0) ? BOOST_4600_MV :
                          (bstv_sel == 2'h1) ? BOOST_4750_MV :
                          (bstv_sel == 2'h2) ? BOOST_5000_MV : BOOST_5150_MV;

   // (RULE9) boost qualification; the automatic pair also permits charge enable
   wire auto_mode  = bst_en & chg_en;
   wire boost_ok   = ~bsd & bst_en & (~chg_en | auto_mode)
                     & sense_i.bat_above_boost_min & sense_i.ts_in_boost_window;
   wire boost_strt = boost_ok & ~sense_i.adapter_present & sense_i.vbus_below_bat_sleep;

   wire in_buck    = mode_q == MODE_BUCK;
   wire in_start   = mode_q == MODE_BUCK_START;
   wire in_boost   = mode_q == MODE_BOOST;
   wire in_hiz     = mode_q == MODE_HIZ;
   wire chg_active = chg_en & ~bsd & ~sense_i.charge_terminated;
   wire linear     = in_buck & sense_i.sys_below_min;

   // (RULE21) next mode from this cycle's inputs
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_IDLE: begin
            // (RULE6) high impedance entry
            if (sense_i.adapter_present && hiz_en) begin
               mode_d = MODE_HIZ;
            end else if (sense_i.adapter_present) begin
               mode_d = MODE_BUCK_START;
            end else if (boost_strt) begin
               mode_d = MODE_BOOST;
            end
         end
         MODE_HIZ: begin
            if (!sense_i.adapter_present) begin
               mode_d = MODE_IDLE;
            end else if (!hiz_en) begin
               mode_d = MODE_BUCK_START;
            end
         end
         MODE_BUCK_START, MODE_BUCK: begin
            // (RULE13) removal goes straight to boost
            if (!sense_i.adapter_present && auto_mode && boost_strt) begin
               mode_d = MODE_BOOST;
            end else if (!sense_i.adapter_present) begin
               mode_d = MODE_IDLE;
            end else if (hiz_en) begin
               mode_d = MODE_HIZ;
            end else if (in_start && sense_i.current_limit_established) begin
               // (RULE3) converter starts after limit
               mode_d = MODE_BUCK;
            end
         end
         MODE_BOOST: begin
            // (RULE12) adapter returns to charging
            if (sense_i.adapter_present && auto_mode && sense_i.new_charge_ok) begin
               mode_d = MODE_BUCK_START;
            end else if (!boost_ok) begin
               mode_d = MODE_IDLE;
            end
         end
         default: mode_d = MODE_IDLE;
      endcase
   end

   // (RULE18) supplement entry
   // (RULE19) depletion exit wins
   assign supp_d = sense_i.bat_depleted ? 1'b0 :
                   (in_buck & sense_i.charge_current_zero & sense_i.sys_below_bat) ? 1'b1 :
                   (supp_q & in_buck);

   always_comb begin
      pwr_d = '0;
      // (RULE3) buck switches
      pwr_d.buck_switches_en         = in_buck;
      // (RULE11) blocking switch off in boost
      pwr_d.input_blocking_switch_on = in_start | in_buck;
      // (RULE20) regulator off in high impedance
      pwr_d.internal_regulator_on    = in_start | in_buck | in_boost;
      pwr_d.bias_on                  = in_start | in_buck | in_boost;
      // (RULE3) battery switch per charge enable
      // (RULE19) depletion forces the switch off
      pwr_d.battery_switch_on        = (bsd | sense_i.bat_depleted) ? 1'b0 :
                                       in_buck ? (chg_active | supp_d | linear) : 1'b1;
      // (RULE14) linear operation
      pwr_d.battery_switch_linear    = linear & ~bsd;
      pwr_d.boost_en                 = in_boost;
      // (RULE5) light-load operation
      pwr_d.light_load_en            = ~lld & (in_buck | in_boost);
      // (RULE16) charge current reduction
      pwr_d.charge_reduce            = in_buck &
                                       (sense_i.input_current_over | sense_i.input_voltage_under);
      pwr_d.supplement               = supp_d;
      // (RULE14) regulation reference
      pwr_d.sys_ref_battery          = in_buck & ~chg_active & ~sense_i.sys_below_min;
      pwr_d.sys_offset_mv            = (in_buck & ~chg_active & ~sense_i.sys_below_min)
                                       ? SYS_BAT_OFS_MV : SYS_MIN_OFS_MV;
      pwr_d.vds_min_mv               = supp_d ? SUPP_VDS_MV : 16'h0000;
      pwr_d.input_voltage_limit_mv   = vlim_eff;
      pwr_d.input_current_limit_ma   = ilim_eff;
      pwr_d.boost_target_mv          = bst_mv;
      pwr_d.boost_current_max_ma     = BOOST_IMAX_MA;
   end

   always_comb begin
      status_d = 32'h0000_0000;
      // (RULE10) boost status code
      status_d[ST_VBUS_LSB +: 3] = in_boost ? VBUS_BOOST :
                                   sense_i.adapter_present ? sense_i.source_type : VBUS_NONE;
      // (RULE15) minimum system flag
      status_d[ST_MINSYS_BIT]    = linear;
      // (RULE17) limit status flags
      status_d[ST_VLIM_BIT]      = in_buck & sense_i.input_voltage_under;
      status_d[ST_ILIM_BIT]      = in_buck & sense_i.input_current_over;
      status_d[ST_SUPP_BIT]      = supp_d;
      status_d[ST_CLAMP_BIT]     = clamp_q;
      status_d[ST_MODE_LSB +: 3] = mode_q;
      status_d[ST_BATSW_BIT]     = pwr_d.battery_switch_on;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         waitreq_q <= 1'b1;
         rdata_q   <= 32'h0000_0000;
      end else begin
         // One wait cycle, then a single low cycle that completes the transfer
         waitreq_q <= ~(req & waitreq_q);
         rdata_q   <= (read_i & waitreq_q) ? rd_mux : rdata_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_q <= CTRL_RESET;
         vlim_q <= VLIM_RESET_MV;
         ilim_q <= ILIM_RESET_MA;
      end else if (wr_acc) begin
         ctrl_q <= sel_ctrl ? ctrl_new : ctrl_q;
         vlim_q <= sel_vlim ? vlim_new : vlim_q;
         ilim_q <= sel_ilim ? ilim_raw[15:0] : ilim_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         mode_q   <= MODE_IDLE;
         clamp_q  <= 1'b1;
         supp_q   <= 1'b0;
         pwr_q    <= '0;
         status_q <= 32'h0000_0000;
      end else begin
         mode_q   <= mode_d;
         // (RULE4) hysteresis between the two thresholds
         clamp_q  <= sense_i.sys_below_short | (clamp_q & ~sense_i.sys_above_short_release);
         supp_q   <= supp_d;
         pwr_q    <= pwr_d;
         status_q <= status_d;
      end
   end

   assign readdata_o    = rdata_q;
   assign waitrequest_o = waitreq_q;
   assign power_o       = pwr_q;
   assign mode_o        = status_q[ST_MODE_LSB +: 3];

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_bus_answer;
      req && waitreq_q |=> !waitreq_q ##1 waitreq_q;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

   property p_vlim_floor;
      $past(rst_n_i) |-> pwr_q.input_voltage_limit_mv >= $past(vlim_q)
      && $past(vlim_q) >= VLIM_MIN_MV && $past(vlim_q) <= VLIM_MAX_MV;
   endproperty
   a_vlim_floor: assert property (p_vlim_floor) else $error("voltage limit wrong"); // RULE1

   property p_track;
      $past(trk_sel) != 2'h0 && $past(trk_sum[16]) == 1'b0
      |-> pwr_q.input_voltage_limit_mv >= $past(trk_sum[15:0]);
   endproperty
   a_track: assert property (p_track) else $error("tracking limit too low"); // RULE2

   property p_buck_on;
      in_buck |=> pwr_q.buck_switches_en && pwr_q.input_blocking_switch_on;
   endproperty
   a_buck_on: assert property (p_buck_on) else $error("buck switches not on"); // RULE3

   property p_soft_clamp;
      sense_i.sys_below_short |=> ##1 pwr_q.input_current_limit_ma <= SOFT_ILIM_MA;
   endproperty
   a_soft_clamp: assert property (p_soft_clamp) else $error("soft start clamp missing"); // RULE4

   property p_light_load;
      (in_buck || in_boost) && !lld |=> pwr_q.light_load_en;
   endproperty
   a_light_load: assert property (p_light_load) else $error("light load off"); // RULE5

   property p_hiz_off;
      in_hiz |=> !pwr_q.internal_regulator_on && !pwr_q.input_blocking_switch_on
                 && !pwr_q.bias_on;
   endproperty
   a_hiz_off: assert property (p_hiz_off) else $error("hiz left supplies on"); // RULE6

   property p_boost_entry;
      mode_q == MODE_BOOST && $past(mode_q) != MODE_BOOST
      |-> $past(boost_ok) && !$past(bsd) && $past(bst_en);
   endproperty
   a_boost_entry: assert property (p_boost_entry) else $error("boost without qualification"); // RULE9

   property p_boost_status;
      in_boost [*2] |-> status_q[ST_VBUS_LSB +: 3] == VBUS_BOOST;
   endproperty
   a_boost_status: assert property (p_boost_status) else $error("boost status not 111"); // RULE10

   property p_boost_input_blocking_switch;
      pwr_q.boost_en |-> !pwr_q.input_blocking_switch_on;
   endproperty
   a_boost_input_blocking_switch: assert property (p_boost_input_blocking_switch) else $error("blocking switch on in boost"); // RULE11

   property p_auto_charge;
      in_boost && sense_i.adapter_present && auto_mode && sense_i.new_charge_ok
      |=> mode_q == MODE_BUCK_START;
   endproperty
   a_auto_charge: assert property (p_auto_charge) else $error("no return to charging"); // RULE12

   property p_minsys;
      in_buck && sense_i.sys_below_min |=> status_q[ST_MINSYS_BIT];
   endproperty
   a_minsys: assert property (p_minsys) else $error("min system flag missing"); // RULE15

   property p_dpm_flag;
      in_buck && sense_i.input_voltage_under |=> status_q[ST_VLIM_BIT] && pwr_q.charge_reduce;
   endproperty
   a_dpm_flag: assert property (p_dpm_flag) else $error("voltage limit flag missing"); // RULE17

   property p_deplete;
      sense_i.bat_depleted |=> !supp_q && !pwr_q.supplement && !pwr_q.battery_switch_on;
   endproperty
   a_deplete: assert property (p_deplete) else $error("supplement kept at depletion"); // RULE19
endmodule : power_path_mode_control
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        clk_i,
   input  wire logic        waitrequest_i,
   input  wire logic [31:0] readdata_i,
   output logic      [7:0]  address_o,
   output logic             read_o,
   output logic             write_o,
   output logic      [31:0] writedata_o
);
   initial begin
      address_o = 8'h00;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = 32'h0000_0000;
   end
   // Request stands until the edge that sees waitrequest low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      address_o <= a;
      writedata_o <= d;
      write_o <= w;
      read_o <= !w;
      @(posedge clk_i);
      while (waitrequest_i !== 1'b0) @(posedge clk_i);
      q = readdata_i;
      read_o <= 1'b0;
      write_o <= 1'b0;
      // One idle edge so no strobe is driven twice in a step
      @(posedge clk_i);
   endtask : xfer
endmodule : host_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import power_path_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        wait_rq;
   sense_s      sense = '0;
   power_ctrl_s pwr;
   logic [2:0]  mode;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          vlim_m = VLIM_RESET_MV;
   int          ilim_m = ILIM_RESET_MA;
   int          ofs_t[4] = '{0, TRK_OFS1_MV, TRK_OFS2_MV, TRK_OFS3_MV};
   int          bst_t[4] = '{BOOST_4600_MV, BOOST_4750_MV, BOOST_5000_MV, BOOST_5150_MV};
   always #2.5 clk = ~clk;
   power_path_mode_control dut (.core_clk_i(clk), .rst_n_i(rst_n), .address_i(addr),
      .read_i(rd), .write_i(wr), .writedata_i(wdata), .byteenable_i(4'hF),
      .readdata_o(rdata), .waitrequest_o(wait_rq), .sense_i(sense), .power_o(pwr),
      .mode_o(mode));
   host_model host (.clk_i(clk), .waitrequest_i(wait_rq), .readdata_i(rdata),
      .address_o(addr), .read_o(rd), .write_o(wr), .writedata_o(wdata));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b1, a, d, q);
      if (a == REG_VLIM_OFS) vlim_m = d < VLIM_MIN_MV ? VLIM_MIN_MV :
                                      d > VLIM_MAX_MV ? VLIM_MAX_MV : d;
      if (a == REG_ILIM_OFS) ilim_m = d[15:0];
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input string nm, input logic [31:0] e);
      logic [31:0] q;
      host.xfer(1'b0, a, 32'h0000_0000, q);
      chk(nm, e, q);
   endtask : rreg
   // Covers the mode register lag behind the sensed inputs
   task automatic settle;
      repeat (8) @(posedge clk);
   endtask : settle
   initial begin
      #50000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      int b;
      sense_s s_v;
      void'($urandom(93));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rreg(REG_CTRL_OFS, "ctrl", CTRL_RESET);
      rreg(8'h18, "unmapped", 32'h0000_0000);
      rreg(REG_VLIM_OFS, "vlim", vlim_m);
      repeat (8) begin
         wreg(REG_VLIM_OFS, $urandom_range(16'h0BB8, 16'h1770));
         rreg(REG_VLIM_OFS, "vlim", vlim_m);
      end
      for (int t = 0; t < 4; t++) begin
         b = $urandom_range(16'h0DAC, 16'h14B4);
         sense.bat_mv <= b[15:0];
         wreg(REG_CTRL_OFS, CTRL_RESET | (t << CTRL_TRK_LSB));
         settle();
         b = t == 0 ? vlim_m : (b + ofs_t[t] > vlim_m ? b + ofs_t[t] : vlim_m);
         rreg(REG_VLIM_EFF_OFS, "vlim_eff", b);
      end
      $display("test limits done");
      sense.adapter_present <= 1'b1;
      sense.current_limit_established <= 1'b1;
      sense.new_charge_ok <= 1'b1;
      sense.sys_below_short <= 1'b1;
      wreg(REG_CTRL_OFS, CTRL_RESET);
      wreg(REG_ILIM_OFS, 32'h0000_03E8);
      settle();
      chk("buck", {3'h3, 3'h7}, {mode, pwr.buck_switches_en, pwr.battery_switch_on,
          pwr.light_load_en});
      rreg(REG_ILIM_EFF_OFS, "ilim_clamp", SOFT_ILIM_MA);
      wreg(REG_ILIM_OFS, 32'h0000_0096);
      rreg(REG_ILIM_EFF_OFS, "ilim_clamp", ilim_m);
      sense.sys_below_short <= 1'b0;
      sense.sys_above_short_release <= 1'b1;
      wreg(REG_ILIM_OFS, 32'h0000_03E8);
      wreg(REG_CTRL_OFS, 32'h0000_0102);
      settle();
      rreg(REG_ILIM_EFF_OFS, "ilim", ilim_m);
      chk("buck_off", {2'b00, 1'b1, SYS_BAT_OFS_MV}, {pwr.battery_switch_on, pwr.light_load_en,
          pwr.sys_ref_battery, pwr.sys_offset_mv});
      sense.input_voltage_under <= 1'b1;
      sense.sys_below_min <= 1'b1;
      settle();
      // Buck mode, minimum-system regulation with the battery switch on
      b = (1 << ST_BATSW_BIT) | (3 << ST_MODE_LSB) | (1 << ST_MINSYS_BIT);
      rreg(REG_STATUS_OFS, "dpm_v", b | (1 << ST_VLIM_BIT));
      chk("reduce", 1'b1, pwr.charge_reduce);
      sense.input_voltage_under <= 1'b0;
      sense.input_current_over <= 1'b1;
      settle();
      chk("reduce_i", 1'b1, pwr.charge_reduce);
      rreg(REG_STATUS_OFS, "dpm_i", b | (1 << ST_ILIM_BIT));
      sense.charge_current_zero <= 1'b1;
      sense.sys_below_bat <= 1'b1;
      settle();
      chk("supp", {1'b1, SUPP_VDS_MV, 1'b1}, {pwr.supplement, pwr.vds_min_mv,
          pwr.battery_switch_on});
      sense.bat_depleted <= 1'b1;
      settle();
      chk("deplete", 2'b00, {pwr.supplement, pwr.battery_switch_on});
      wreg(REG_CTRL_OFS, CTRL_RESET | 32'h0000_0001);
      settle();
      chk("hiz", 6'h08, {mode, pwr.input_blocking_switch_on, pwr.internal_regulator_on,
          pwr.bias_on});
      $display("test buck done");
      s_v = '0;
      s_v.bat_mv = 16'h0FA0;
      s_v.bat_above_boost_min = 1'b1;
      s_v.vbus_below_bat_sleep = 1'b1;
      s_v.ts_in_boost_window = 1'b1;
      sense <= s_v;
      for (int i = 0; i < 4; i++) begin
         wreg(REG_CTRL_OFS, (i << CTRL_BSTV_LSB) | 32'h0000_0008);
         settle();
         chk("bst", {3'h4, 2'b10, 16'(bst_t[i])}, {mode, pwr.boost_en,
             pwr.input_blocking_switch_on, pwr.boost_target_mv});
      end
      wreg(REG_CTRL_OFS, 32'h0000_0118);
      settle();
      chk("bsd_blocks", 1'b0, pwr.boost_en);
      wreg(REG_CTRL_OFS, 32'h0000_010C);
      settle();
      chk("auto_bst", 3'h4, mode);
      sense.adapter_present <= 1'b1;
      sense.current_limit_established <= 1'b1;
      sense.new_charge_ok <= 1'b1;
      settle();
      chk("auto_chg", 3'h3, mode);
      sense.adapter_present <= 1'b0;
      settle();
      chk("auto_rm", 3'h4, mode);
      $display("test boost done");
      finish_test();
   end
endmodule : tb
`default_nettype wire
